// ---- core_pkg.sv ----
// constants, opcode decodes and carrier types for the 8-bit core datapath
// assumes a synchronous program memory and a byte-wide data register file
// How it works
// RULE1: one whole 14-bit word is fetched each cycle over a program bus apart from the data bus.
// RULE2: fetch of the next word overlaps execution of the current one, so plain instructions take one cycle.
// RULE3: program space is 512 or 1K words of 14 bits, all inside the device.
// RULE4: special registers, the program counter among them, sit in the data map, reachable directly and indirectly.
// RULE5: the arithmetic unit is 8 bits wide and adds, subtracts, shifts and does logic.
// RULE6: arithmetic is two's complement unless an instruction says otherwise.
// RULE7: two-operand work takes the accumulator and either a file register or a literal.
// RULE8: single-operand work takes either the accumulator or a file register.
// RULE9: the accumulator is 8 bits and has no data address.
// RULE10: carry, digit carry and zero in the flags register update as the instruction dictates.
// RULE11: in subtraction carry and digit carry are inverted borrows out of bit 7 and bit 3.
// RULE12: a branch flushes the fetched word and costs one extra refill cycle.
`default_nettype none
package core_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W_SMALL = 9;
    localparam int PC_W_LARGE = 10;
    localparam logic [INSN_W-1:0] NOP_WORD = 14'h0000;
    // special locations in the data map
    localparam logic [FADDR_W-1:0] ADDR_INDIRECT = 7'h00;
    localparam logic [FADDR_W-1:0] ADDR_PCL = 7'h02;
    localparam logic [FADDR_W-1:0] ADDR_FLAGS = 7'h03;
    localparam logic [FADDR_W-1:0] ADDR_POINTER = 7'h04;
    localparam logic [FADDR_W-1:0] ADDR_PCHIGH = 7'h0A;
    // flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam logic [DATA_W-1:0] FLAGS_RST = 8'h18;
    localparam logic [DATA_W-1:0] POINTER_RST = 8'h00;
    localparam logic [DATA_W-1:0] PCHIGH_RST = 8'h00;

    typedef enum logic [3:0]
    {
        OP_PASS = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_AND = 4'h3,
        OP_IOR = 4'h4, OP_XOR = 4'h5, OP_COM = 4'h6, OP_INC = 4'h7,
        OP_DEC = 4'h8, OP_RLF = 4'h9, OP_RRF = 4'hA, OP_SWAP = 4'hB,
        OP_CLR = 4'hC, OP_BCF = 4'hD, OP_BSF = 4'hE
    } alu_op_t;

    // update masks: bit0 carry, bit1 digit carry, bit2 zero
    typedef struct packed
    {
        alu_op_t op;
        logic [2:0] upd;
    } alu_ctl_t;

    typedef struct packed
    {
        logic [DATA_W-1:0] a;
        logic [DATA_W-1:0] b;
        logic carry_in;
        logic [2:0] bit_sel;
    } alu_in_t;

    typedef struct packed
    {
        logic [DATA_W-1:0] res;
        logic c;
        logic dc;
        logic z;
    } alu_out_t;

    typedef struct packed
    {
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
    } file_req_t;

    typedef enum logic [1:0]
    {
        PIPE_RUN = 2'b01,
        PIPE_FLUSH = 2'b10
    } pipe_state_t;
endpackage
`default_nettype wire

// ---- core_alu.sv ----
// 8-bit arithmetic unit with carry, digit carry and zero
// assumes operands and control are settled within the cycle
`default_nettype none
module core_alu
    import core_pkg::*;
(
    input wire alu_ctl_t ctl,
    input wire alu_in_t din,
    output alu_out_t dout
);
    logic [DATA_W:0] sum;
    logic [4:0] nib;
    logic [DATA_W-1:0] bmask;
    logic [DATA_W-1:0] res;
    logic c;
    logic dc;

    assign bmask = 8'h01 << din.bit_sel;

    // RULE5 RULE6 arithmetic core
    always_comb
    begin
        sum = 9'h000;
        nib = 5'h00;
        res = din.a;
        c = din.carry_in;
        dc = 1'b0;
        case (ctl.op)
            OP_PASS: res = din.a;
            OP_ADD:
            begin
                sum = {1'b0, din.a} + {1'b0, din.b};
                nib = {1'b0, din.a[3:0]} + {1'b0, din.b[3:0]};
                res = sum[DATA_W-1:0];
                c = sum[DATA_W];
                dc = nib[4];
            end
            // RULE11 inverted borrow flags
            OP_SUB:
            begin
                sum = {1'b0, din.a} + {1'b0, ~din.b} + 9'h001;
                nib = {1'b0, din.a[3:0]} + {1'b0, ~din.b[3:0]} + 5'h01;
                res = sum[DATA_W-1:0];
                c = sum[DATA_W];
                dc = nib[4];
            end
            OP_AND: res = din.a & din.b;
            OP_IOR: res = din.a | din.b;
            OP_XOR: res = din.a ^ din.b;
            OP_COM: res = ~din.a;
            OP_INC: res = din.a + 8'h01;
            OP_DEC: res = din.a - 8'h01;
            OP_RLF:
            begin
                res = {din.a[6:0], din.carry_in};
                c = din.a[7];
            end
            OP_RRF:
            begin
                res = {din.carry_in, din.a[7:1]};
                c = din.a[0];
            end
            OP_SWAP: res = {din.a[3:0], din.a[7:4]};
            OP_CLR: res = 8'h00;
            OP_BCF: res = din.a & ~bmask;
            OP_BSF: res = din.a | bmask;
            default: res = din.a;
        endcase
    end

    assign dout.res = res;
    assign dout.c = c;
    assign dout.dc = dc;
    assign dout.z = (res == 8'h00);
endmodule
`default_nettype wire

// ---- core_datapath.sv ----
// fetch/execute core: pipeline, decode, accumulator, flags and special registers
// assumes program memory answers one cycle after the address, and the file
// register array answers reads combinationally and writes on the clock edge
`default_nettype none
module core_datapath
    import core_pkg::*;
#(
    parameter int PC_W = PC_W_LARGE
)
(
    input wire logic clk,
    input wire logic rst,
    output logic [PC_W-1:0] prog_addr,
    input wire logic [INSN_W-1:0] prog_data,
    output file_req_t file_req,
    input wire logic [DATA_W-1:0] file_rdata,
    output logic [DATA_W-1:0] acc_value,
    output logic [DATA_W-1:0] flags_value,
    output logic [PC_W-1:0] pc_value
);
    logic [PC_W-1:0] pc_q, pc_d;
    logic [INSN_W-1:0] ir;
    logic [DATA_W-1:0] acc_q, acc_d;
    logic [DATA_W-1:0] flags_q, flags_d;
    logic [DATA_W-1:0] ptr_q, ptr_d;
    logic [DATA_W-1:0] pch_q, pch_d;
    pipe_state_t st_q, st_d;

    alu_ctl_t ctl;
    alu_in_t ain;
    alu_out_t aout;

    // RULE1 RULE3 full word from a separate program bus, PC_W sizes the space
    assign prog_addr = pc_q;
    // RULE12 the word fetched under a branch is replaced by a no-op
    assign ir = (st_q == PIPE_FLUSH) ? NOP_WORD : prog_data;

    // instruction fields
    wire [1:0] grp = ir[13:12];
    wire [3:0] sub = ir[11:8];
    wire dest_f = ir[7];
    wire [FADDR_W-1:0] faddr_dir = ir[6:0];
    wire [DATA_W-1:0] lit = ir[7:0];
    wire [2:0] bitn = ir[9:7];

    wire is_byte = (grp == 2'b00);
    wire is_bit = (grp == 2'b01);
    wire is_ctl = (grp == 2'b10);
    wire is_lit = (grp == 2'b11);

    wire is_movwf = is_byte && (sub == 4'h0) && dest_f;
    wire is_clrw = is_byte && (sub == 4'h1) && !dest_f;
    wire is_goto = is_ctl && ir[11];
    wire is_retlw = is_lit && (ir[11:10] == 2'b01);
    wire is_bsf_c = is_bit && (ir[11:10] == 2'b01);
    wire is_btfss = is_bit && (ir[11:10] == 2'b11);
    wire is_btfsc = is_bit && (ir[11:10] == 2'b10);
    wire is_decfsz = is_byte && (sub == 4'hB);
    wire is_incfsz = is_byte && (sub == 4'hF);

    // RULE4 indirect access through the pointer location
    wire [FADDR_W-1:0] faddr = (faddr_dir == ADDR_INDIRECT) ? ptr_q[FADDR_W-1:0] : faddr_dir;

    // RULE4 special registers answer from the core, the rest from the file
    logic [DATA_W-1:0] fval;
    always_comb
    begin
        case (faddr)
            ADDR_PCL: fval = pc_q[7:0];
            ADDR_FLAGS: fval = flags_q;
            ADDR_POINTER: fval = ptr_q;
            ADDR_PCHIGH: fval = pch_q;
            default: fval = file_rdata;
        endcase
    end

    function automatic alu_op_t byte_op(input logic [3:0] s);
        case (s)
            4'h0: byte_op = OP_PASS;
            4'h1: byte_op = OP_CLR;
            4'h2: byte_op = OP_SUB;
            4'h3: byte_op = OP_DEC;
            4'h4: byte_op = OP_IOR;
            4'h5: byte_op = OP_AND;
            4'h6: byte_op = OP_XOR;
            4'h7: byte_op = OP_ADD;
            4'h8: byte_op = OP_PASS;
            4'h9: byte_op = OP_COM;
            4'hA: byte_op = OP_INC;
            4'hB: byte_op = OP_DEC;
            4'hC: byte_op = OP_RRF;
            4'hD: byte_op = OP_RLF;
            4'hE: byte_op = OP_SWAP;
            4'hF: byte_op = OP_INC;
            default: byte_op = OP_PASS;
        endcase
    endfunction

    function automatic logic [2:0] byte_upd(input logic [3:0] s);
        case (s)
            4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA: byte_upd = 3'h4;
            4'h2, 4'h7: byte_upd = 3'h7;
            4'hC, 4'hD: byte_upd = 3'h1;
            default: byte_upd = 3'h0;
        endcase
    endfunction

    function automatic alu_op_t lit_op(input logic [3:0] s);
        case (s[3:1])
            3'b100: lit_op = OP_IOR;
            3'b101: lit_op = OP_AND;
            3'b110: lit_op = OP_XOR;
            3'b111: lit_op = s[0] ? OP_ADD : OP_SUB;
            default: lit_op = OP_PASS;
        endcase
    endfunction

    // RULE7 RULE8 operand steering; subtraction takes the accumulator off the other side
    always_comb
    begin
        ctl.op = OP_PASS;
        ctl.upd = 3'h0;
        ain.a = fval;
        ain.b = acc_q;
        ain.carry_in = flags_q[FLAG_C];
        ain.bit_sel = bitn;
        if (is_byte && !is_movwf)
        begin
            ctl.op = byte_op(sub);
            ctl.upd = byte_upd(sub);
            if (sub == 4'h0 || sub == 4'h1)
                ain.a = acc_q;
        end
        else if (is_bit && !ir[11])
        begin
            ctl.op = is_bsf_c ? OP_BSF : OP_BCF;
        end
        else if (is_lit)
        begin
            ctl.op = lit_op(sub);
            ain.a = lit;
            // only the two arithmetic literal forms touch carry; a return literal leaves flags
            if (sub[3:1] == 3'b111)
                ctl.upd = 3'h7;
            else if (sub[3])
                ctl.upd = 3'h4;
        end
    end

    core_alu u_alu
    (
        .ctl(ctl),
        .din(ain),
        .dout(aout)
    );

    wire alu_writes_f = (is_byte && dest_f && !(sub == 4'h0 && !is_movwf)) || (is_bit && !ir[11]);
    wire [DATA_W-1:0] wval = is_movwf ? acc_q : aout.res;
    wire skip = (is_btfsc && !fval[bitn]) || (is_btfss && fval[bitn])
        || ((is_decfsz || is_incfsz) && aout.z);
    wire pc_write = alu_writes_f && (faddr == ADDR_PCL);
    wire branch = is_ctl || is_retlw || skip || pc_write;

    // RULE9 accumulator only changes through instruction destinations
    always_comb
    begin
        acc_d = acc_q;
        if ((is_byte && !dest_f && sub != 4'h0) || is_clrw)
            acc_d = aout.res;
        else if (is_lit)
            acc_d = aout.res;
    end

    // RULE10 flags follow the per-instruction update mask
    always_comb
    begin
        flags_d = flags_q;
        if (alu_writes_f && faddr == ADDR_FLAGS)
            flags_d = wval;
        if (ctl.upd[0])
            flags_d[FLAG_C] = aout.c;
        if (ctl.upd[1])
            flags_d[FLAG_DC] = aout.dc;
        if (ctl.upd[2])
            flags_d[FLAG_Z] = aout.z;
    end

    assign ptr_d = (alu_writes_f && faddr == ADDR_POINTER) ? wval : ptr_q;
    assign pch_d = (alu_writes_f && faddr == ADDR_PCHIGH) ? wval : pch_q;

    // full-width targets, cut to the program space below
    wire [12:0] goto_full = {pch_q[4:3], ir[10:0]};
    wire [2*DATA_W-1:0] pcl_full = {pch_q, wval};

    // RULE2 the next address is always fetching while this word executes
    always_comb
    begin
        pc_d = pc_q + PC_W'(1);
        if (is_goto || (is_ctl && !ir[11]))
            pc_d = goto_full[PC_W-1:0];
        else if (pc_write)
            pc_d = pcl_full[PC_W-1:0];
    end

    // RULE12 any branch spends one refill cycle
    assign st_d = branch ? PIPE_FLUSH : PIPE_RUN;

    assign file_req.addr = faddr;
    assign file_req.wdata = wval;
    assign file_req.we = (alu_writes_f || is_movwf) && (st_q == PIPE_RUN);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pc_q <= '0;
            acc_q <= 8'h00;
            flags_q <= FLAGS_RST;
            ptr_q <= POINTER_RST;
            pch_q <= PCHIGH_RST;
            st_q <= PIPE_FLUSH;
        end
        else
        begin
            pc_q <= pc_d;
            acc_q <= acc_d;
            flags_q <= flags_d;
            ptr_q <= ptr_d;
            pch_q <= pch_d;
            st_q <= st_d;
        end
    end

    assign acc_value = acc_q;
    assign flags_value = flags_q;
    assign pc_value = pc_q;
endmodule
`default_nettype wire

// ---- core_datapath_props.sv ----
// concurrent checks on the core datapath ports
// assumes binding to core_datapath; flushes follow jumps and pc writes,
// and any skipped word is one that no check here decodes
`default_nettype none
module core_datapath_props
    import core_pkg::*;
#(
    parameter int PC_W = PC_W_LARGE
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [PC_W-1:0] prog_addr,
    input wire logic [INSN_W-1:0] prog_data,
    input wire file_req_t file_req,
    input wire logic [DATA_W-1:0] file_rdata,
    input wire logic [DATA_W-1:0] acc_value,
    input wire logic [DATA_W-1:0] flags_value,
    input wire logic [PC_W-1:0] pc_value
);
    logic flush_q;
    wire logic run = !flush_q;
    wire logic jump = run && prog_data[13:11] == 3'h5;
    wire logic ld_lit = run && prog_data[13:10] == 4'hC;
    wire logic add_lit = run && prog_data[13:8] == 6'h3F;
    wire logic sub_lit = run && prog_data[13:8] == 6'h3E;
    wire logic st_file = run && prog_data[13:7] == 7'h01 && prog_data[6:0] != ADDR_INDIRECT;
    wire logic sub_file = run && prog_data[13:7] == 7'h05;
    wire logic [PC_W-1:0] jump_to = prog_data[PC_W-1:0];
    wire logic [7:0] lit = prog_data[7:0];
    wire logic [8:0] add_sum = {1'h0, acc_value} + {1'h0, prog_data[7:0]};
    wire logic [4:0] add_lo = {1'h0, acc_value[3:0]} + {1'h0, prog_data[3:0]};
    wire logic [8:0] sub_sum = {1'h0, prog_data[7:0]} - {1'h0, acc_value};
    wire logic [4:0] sub_lo = {1'h0, prog_data[3:0]} - {1'h0, acc_value[3:0]};
    wire logic [7:0] file_diff = file_rdata - acc_value;
    // word after a jump or reset is stale
    always_ff @(posedge clk or posedge rst)
        if (rst)
            flush_q <= 1'h1;
        else
            flush_q <= jump || (file_req.we && file_req.addr == ADDR_PCL);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    fetch_pc_a: assert property (prog_addr == pc_value)
        else $error("fetch address is not the pc");
    pc_step_a: assert property (!jump && !(file_req.we && file_req.addr == ADDR_PCL)
        |=> pc_value == $past(pc_value) + 1'h1) else $error("pc did not step by one");
    jump_target_a: assert property (jump |=> pc_value == $past(jump_to)
        ##1 pc_value == $past(pc_value) + 1'h1) else $error("jump target wrong");
    flush_quiet_a: assert property (flush_q |-> !file_req.we
        ##1 $stable(acc_value) && $stable(flags_value)) else $error("stale word acted");
    load_lit_a: assert property (ld_lit |-> !file_req.we ##1 acc_value == $past(lit))
        else $error("literal load wrong");
    add_lit_a: assert property (add_lit |=> {flags_value[FLAG_C], acc_value} == $past(add_sum))
        else $error("add result or carry wrong");
    digit_add_a: assert property (add_lit |=> flags_value[FLAG_DC] == $past(add_lo[4]))
        else $error("add digit carry wrong");
    sub_lit_a: assert property (sub_lit |=> acc_value == $past(sub_sum[7:0])
        && flags_value[FLAG_C] == !$past(sub_sum[8])) else $error("subtract or borrow wrong");
    digit_sub_a: assert property (sub_lit |=> flags_value[FLAG_DC] == !$past(sub_lo[4]))
        else $error("digit borrow wrong");
    zero_flag_a: assert property (add_lit || sub_lit |=>
        flags_value[FLAG_Z] == (acc_value == 8'h00)) else $error("zero flag wrong");
    store_file_a: assert property (st_file |-> file_req.we && file_req.addr == prog_data[6:0]
        && file_req.wdata == acc_value) else $error("file store wrong");
    sub_file_a: assert property (sub_file |-> file_req.we && file_req.wdata == file_diff)
        else $error("file subtract wrong");
endmodule
`default_nettype wire

// ---- core_mem_model.sv ----
// program memory and data register file beside the core
// assumes the bench loads rom words before it pulses reset to restart the core
`default_nettype none
module core_mem_model
    import core_pkg::*;
#(
    parameter int PC_W = PC_W_LARGE
)
(
    input wire logic clk,
    input wire logic [PC_W-1:0] prog_addr,
    output logic [INSN_W-1:0] prog_data,
    input wire file_req_t file_req,
    output logic [DATA_W-1:0] file_rdata
);
    logic [INSN_W-1:0] rom [2**PC_W];
    logic [DATA_W-1:0] ram [2**FADDR_W];
    initial
    begin
        foreach (rom[i]) rom[i] = NOP_WORD;
        foreach (ram[i]) ram[i] = 8'h00;
    end
    always @(posedge clk)
        prog_data <= rom[prog_addr];
    // separate data bus, written on the edge
    always @(posedge clk)
        if (file_req.we)
            ram[file_req.addr] <= file_req.wdata;
    assign file_rdata = ram[file_req.addr];
endmodule
`default_nettype wire

// ---- tb_core_datapath.sv ----
// self-checking bench for the core datapath with its memory model
// assumes the checker and the memory model are compiled first
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_core_datapath
    import core_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC_W = PC_W_LARGE;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [PC_W-1:0] prog_addr, pc_value;
    logic [INSN_W-1:0] prog_data;
    file_req_t file_req;
    logic [DATA_W-1:0] file_rdata, acc_value, flags_value;
    int err_count = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    core_datapath #(.PC_W(PC_W)) core_datapath_inst (.clk(clk), .rst(rst),
        .prog_addr(prog_addr), .prog_data(prog_data), .file_req(file_req),
        .file_rdata(file_rdata), .acc_value(acc_value), .flags_value(flags_value),
        .pc_value(pc_value));
    core_mem_model #(.PC_W(PC_W)) core_mem_model_inst (.clk(clk), .prog_addr(prog_addr),
        .prog_data(prog_data), .file_req(file_req), .file_rdata(file_rdata));
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic put(input int a, input logic [INSN_W-1:0] w);
        core_mem_model_inst.rom[a] = w;
    endtask
    // one cycle per plain word, so a short fixed run settles any program here
    task automatic go();
        rst = 1'h1;
        repeat (6) @(posedge clk);
        #1 rst = 1'h0;
        repeat (14) @(posedge clk);
        #1;
    endtask
    // load literal w, then op with literal k, then park
    task automatic lit2(input logic [5:0] op, input logic [7:0] w, input logic [7:0] k,
        input logic [7:0] res, input logic [2:0] fl);
        put(0, {6'h30, w});
        put(1, {op, k});
        put(2, 14'h2802);
        go();
        `CHK(acc_value, res);
        `CHK(flags_value[2:0], fl);
    endtask
    task automatic t_reset();
        rst = 1'h1;
        @(posedge clk);
        #1;
        `CHK(acc_value, 8'h00);
        `CHK(flags_value, FLAGS_RST);
        `CHK(pc_value, 10'h000);
        $display("reset test done");
    endtask
    task automatic t_add();
        lit2(6'h3F, 8'h0F, 8'h01, 8'h10, 3'h2);
        lit2(6'h3F, 8'hF0, 8'h10, 8'h00, 3'h5);
        $display("add test done");
    endtask
    task automatic t_sub();
        lit2(6'h3E, 8'h05, 8'h03, 8'hFE, 3'h0);
        lit2(6'h3E, 8'h03, 8'h05, 8'h02, 3'h3);
        lit2(6'h3E, 8'h05, 8'h05, 8'h00, 3'h7);
        $display("subtract test done");
    endtask
    // literal logic touches zero only, so carry and digit carry stay clear
    task automatic t_logic();
        lit2(6'h38, 8'h50, 8'h0A, 8'h5A, 3'h0);
        lit2(6'h3A, 8'h0F, 8'hF0, 8'h00, 3'h4);
        lit2(6'h3C, 8'hFF, 8'h0F, 8'hF0, 3'h0);
        $display("logic test done");
    endtask
    // set a bit, skip over a clear on it, rotate in place, then jump by a pc write
    task automatic t_bits();
        put(0, 14'h3001);
        put(1, 14'h00A1);
        put(2, 14'h17A1);
        put(3, 14'h1FA1);
        put(4, 14'h01A1);
        put(5, 14'h0DA1);
        put(6, 14'h3009);
        put(7, 14'h0082);
        put(8, 14'h30EE);
        put(9, 14'h2809);
        go();
        `CHK(core_mem_model_inst.ram[7'h21], 8'h02);
        `CHK(acc_value, 8'h09);
        `CHK(flags_value[2:0], 3'h1);
        $display("bit and skip test done");
    endtask
    task automatic t_file();
        put(0, 14'h305A);
        put(1, 14'h00A0);
        put(2, 14'h3010);
        put(3, 14'h02A0);
        put(4, 14'h3020);
        put(5, 14'h0084);
        put(6, 14'h0800);
        put(7, 14'h2807);
        go();
        `CHK(core_mem_model_inst.ram[7'h20], 8'h4A);
        `CHK(acc_value, 8'h4A);
        `CHK(flags_value[2:0], 3'h3);
        $display("file test done");
    endtask
    task automatic t_branch();
        int cnt;
        put(0, 14'h2805);
        put(1, 14'h30EE);
        put(5, 14'h3011);
        put(6, 14'h2806);
        rst = 1'h1;
        repeat (6) @(posedge clk);
        #1 rst = 1'h0;
        cnt = 0;
        while (acc_value !== 8'h11 && cnt < 20)
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
        // flush, jump, refill, target
        `CHK(cnt, 4);
        $display("branch test done");
    endtask
    initial
    begin
        t_reset();
        t_add();
        t_sub();
        t_logic();
        t_file();
        t_bits();
        t_branch();
        close_out();
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        err_count++;
        close_out();
    end
endmodule
bind core_datapath core_datapath_props #(.PC_W(PC_W)) core_datapath_props_inst (.clk(clk),
    .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data), .file_req(file_req),
    .file_rdata(file_rdata), .acc_value(acc_value), .flags_value(flags_value),
    .pc_value(pc_value));
`default_nettype wire
